//--- verilog/free_running_timer_pkg.sv
// Purpose: Shared constants of the free-running capture/compare timer
// Assumes: APB byte addresses, 32-bit data, one aligned word per register
// Notes:   Every offset, field position and count lives here, with the mode, counter and CCR reset values
package free_running_timer_pkg;

   // Register byte addresses
   localparam logic [7:0]  ADDR_CONTROL   = 8'h00;
   localparam logic [7:0]  ADDR_OPTION    = 8'h04;
   localparam logic [7:0]  ADDR_OVF_CLEAR = 8'h08;
   localparam logic [7:0]  ADDR_COUNT     = 8'h0C;
   localparam logic [7:0]  ADDR_CCR0      = 8'h10;
   localparam logic [7:0]  ADDR_CCR1      = 8'h14;

   // Control register fields
   localparam int          MODE_LSB       = 0;
   localparam int          MODE_MSB       = 2;
   localparam int          ENABLE_BIT     = 7;
   localparam logic [2:0]  MODE_FREE_RUN  = 3'h5;

   // Option register fields
   localparam int          OVF_BIT        = 0;
   localparam int          CCS0_BIT       = 4;
   localparam int          CCS1_BIT       = 5;

   // Bit-clear register field
   localparam int          CLEAR_BIT      = 0;

   // Reset and counter values
   localparam logic [2:0]  MODE_RESET     = 3'h0;
   localparam logic [15:0] COUNT_INIT     = 16'h0000;
   localparam logic [15:0] COUNT_MAX      = 16'hFFFF;
   localparam logic [15:0] CCR_RESET      = 16'h0000;

   // System clocks per count clock tick
   localparam int          COUNT_TICK_DIV = 4;

endpackage

//--- verilog/count_tick_divider.sv
// Purpose: Count clock enable pulse derived from the system clock
// Assumes: DIV of at least 1; one pulse every DIV cycles while run is high
// Notes:   Restarts from zero when run falls so ticks align to the start
`timescale 1ns/1ps
module count_tick_divider #(
   parameter int DIV = 4
) (
   input  wire logic clk,
   input  wire logic reset,
   input  wire logic run,
   output logic      tick
);
   localparam logic [7:0] LAST = 8'(DIV - 1);

   logic [7:0] phase;
   logic [7:0] next_phase;
   logic       next_tick;

   // Phase counter; tick is registered from the last phase, so it is high one cycle later
   always_comb begin
      next_phase = phase;
      next_tick  = 1'b0;
      if (!run) begin
         next_phase = 8'h00;
      end else if (phase == LAST) begin
         next_phase = 8'h00;
         next_tick  = 1'b1;
      end else begin
         next_phase = phase + 8'h01;
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         phase <= 8'h00;
         tick  <= 1'b0;
      end else begin
         phase <= next_phase;
         tick  <= next_tick;
      end
   end
endmodule

//--- verilog/capture_compare_channel.sv
// Purpose: One capture/compare channel: register, edge detect, match
// Assumes: trigger is synchronous to clk; rising edge is the valid edge
// Notes:   hit is combinational; the top registers it into irqs, and compare hits into pins
`timescale 1ns/1ps
module capture_compare_channel (
   input  wire logic        clk,
   input  wire logic        reset,
   input  wire logic        running,
   input  wire logic        tick,
   input  wire logic        captureMode,
   input  wire logic        trigger,
   input  wire logic        wrEn,
   input  wire logic [1:0]  wrStrb,
   input  wire logic [15:0] wrData,
   input  wire logic [15:0] count,
   output logic      [15:0] value,
   output logic             hit
);
   logic [15:0] next_value;
   logic        trigPrev;
   logic        next_trigPrev;

   // Register update, capture and compare match
   always_comb begin
      next_trigPrev = trigger;
      next_value    = value;
      hit           = 1'b0;
      // Direct write, no shadow stage: compare sees it next cycle
      if (wrEn) begin
         if (wrStrb[0]) begin
            next_value[7:0] = wrData[7:0];
         end
         if (wrStrb[1]) begin
            next_value[15:8] = wrData[15:8];
         end
      end
      if (captureMode) begin
         // Capture beats a coincident write; counter is left running
         if (running && trigger && !trigPrev) begin
            next_value = count;
            hit        = 1'b1;
         end
      end else if (running && tick && (count == value)) begin
         hit = 1'b1;
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         value    <= free_running_timer_pkg::CCR_RESET;
         trigPrev <= 1'b0;
      end else begin
         value    <= next_value;
         trigPrev <= next_trigPrev;
      end
   end
endmodule

//--- verilog/free_running_timer.sv
// Purpose: 16-bit free-running timer with two capture/compare channels
// Assumes: APB slave, one wait state per transfer; pins synchronous to clk
// Notes:   Count clock is an enable from a fixed divider of clk
`timescale 1ns/1ps
module free_running_timer (
   input  wire logic        clk,
   input  wire logic        reset,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   input  wire logic [3:0]  pstrb,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic        captureTriggerCh0,
   input  wire logic        captureTriggerCh1,
   output logic             timerOutputCh0,
   output logic             timerOutputCh1,
   output logic             channelEventIrqCh0,
   output logic             channelEventIrqCh1,
   output logic             counterOverflowIrq
);
   // Configuration state
   logic [2:0]  modeSelect;
   logic        countEnable;
   logic        ch0Capture;
   logic        ch1Capture;
   logic        overflowFlag;
   logic [2:0]  next_modeSelect;
   logic        next_countEnable;
   logic        next_ch0Capture;
   logic        next_ch1Capture;
   logic        next_overflowFlag;

   // Counter state
   logic [15:0] count;
   logic        runningQ;
   logic [15:0] next_count;
   logic        next_runningQ;
   logic        next_counterOverflowIrq;

   // Pin and channel interrupt state
   logic        next_timerOutputCh0;
   logic        next_timerOutputCh1;
   logic        next_channelEventIrqCh0;
   logic        next_channelEventIrqCh1;

   // Bus state
   logic [31:0] next_prdata;
   logic        next_pready;
   logic        next_pslverr;

   // Decoded strobes and internal events
   logic        running;
   logic        startEvent;
   logic        tick;
   logic        wrapEvent;
   logic        busWrite;
   logic        selKnown;
   logic        wrCcr0;
   logic        wrCcr1;
   logic        optionByteClear;
   logic        bitClear;
   logic [15:0] ccr0Value;
   logic [15:0] ccr1Value;
   logic        ch0Hit;
   logic        ch1Hit;

   // Mode decode and start detection
   assign running    = countEnable
                       && (modeSelect == free_running_timer_pkg::MODE_FREE_RUN);
   assign startEvent = running && !runningQ;
   assign wrapEvent  = running && tick
                       && (count == free_running_timer_pkg::COUNT_MAX);

   // A write takes effect only at the completing access edge
   assign busWrite = psel && penable && pready && pwrite && !pslverr;
   assign wrCcr0   = busWrite && (paddr == free_running_timer_pkg::ADDR_CCR0);
   assign wrCcr1   = busWrite && (paddr == free_running_timer_pkg::ADDR_CCR1);

   // Byte write with bit 0 low; this path wins over a coincident set
   assign optionByteClear = busWrite && pstrb[0]
                            && (paddr == free_running_timer_pkg::ADDR_OPTION)
                            && !pwdata[free_running_timer_pkg::OVF_BIT];
   // Bit-clear operation; loses against a coincident set
   assign bitClear = busWrite && pstrb[0]
                     && (paddr == free_running_timer_pkg::ADDR_OVF_CLEAR)
                     && pwdata[free_running_timer_pkg::CLEAR_BIT];

   // Count clock enable; restarts with each start of counting
   count_tick_divider #(
      .DIV (free_running_timer_pkg::COUNT_TICK_DIV)
   ) u_tick (
      .clk   (clk),
      .reset (reset),
      .run   (running),
      .tick  (tick)
   );

   // Channel 0
   capture_compare_channel u_ch0 (
      .clk         (clk),
      .reset       (reset),
      .running     (running),
      .tick        (tick),
      .captureMode (ch0Capture),
      .trigger     (captureTriggerCh0),
      .wrEn        (wrCcr0),
      .wrStrb      (pstrb[1:0]),
      .wrData      (pwdata[15:0]),
      .count       (count),
      .value       (ccr0Value),
      .hit         (ch0Hit)
   );

   // Channel 1
   capture_compare_channel u_ch1 (
      .clk         (clk),
      .reset       (reset),
      .running     (running),
      .tick        (tick),
      .captureMode (ch1Capture),
      .trigger     (captureTriggerCh1),
      .wrEn        (wrCcr1),
      .wrStrb      (pstrb[1:0]),
      .wrData      (pwdata[15:0]),
      .count       (count),
      .value       (ccr1Value),
      .hit         (ch1Hit)
   );

   // Configuration registers and the sticky overflow flag
   always_comb begin
      next_modeSelect   = modeSelect;
      next_countEnable  = countEnable;
      next_ch0Capture   = ch0Capture;
      next_ch1Capture   = ch1Capture;
      next_overflowFlag = overflowFlag;
      if (busWrite && pstrb[0]
          && (paddr == free_running_timer_pkg::ADDR_CONTROL)) begin
         next_modeSelect  = pwdata[free_running_timer_pkg::MODE_MSB:
                                   free_running_timer_pkg::MODE_LSB];
         next_countEnable = pwdata[free_running_timer_pkg::ENABLE_BIT];
      end
      if (busWrite && pstrb[0]
          && (paddr == free_running_timer_pkg::ADDR_OPTION)) begin
         next_ch0Capture = pwdata[free_running_timer_pkg::CCS0_BIT];
         next_ch1Capture = pwdata[free_running_timer_pkg::CCS1_BIT];
      end
      // Byte write clear first, then set, then bit-clear
      if (optionByteClear) begin
         next_overflowFlag = 1'b0;
      end else if (wrapEvent) begin
         next_overflowFlag = 1'b1;
      end else if (bitClear) begin
         next_overflowFlag = 1'b0;
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         modeSelect   <= free_running_timer_pkg::MODE_RESET;
         countEnable  <= 1'b0;
         ch0Capture   <= 1'b0;
         ch1Capture   <= 1'b0;
         overflowFlag <= 1'b0;
      end else begin
         modeSelect   <= next_modeSelect;
         countEnable  <= next_countEnable;
         ch0Capture   <= next_ch0Capture;
         ch1Capture   <= next_ch1Capture;
         overflowFlag <= next_overflowFlag;
      end
   end

   // Counter, wrap and overflow pulse
   always_comb begin
      next_runningQ           = running;
      next_count              = count;
      next_counterOverflowIrq = 1'b0;
      if (!running) begin
         next_count = free_running_timer_pkg::COUNT_INIT;
      end else if (wrapEvent) begin
         next_count              = free_running_timer_pkg::COUNT_INIT;
         next_counterOverflowIrq = 1'b1;
      end else if (tick) begin
         next_count = count + 16'h0001;
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         count              <= free_running_timer_pkg::COUNT_INIT;
         runningQ           <= 1'b0;
         counterOverflowIrq <= 1'b0;
      end else begin
         count              <= next_count;
         runningQ           <= next_runningQ;
         counterOverflowIrq <= next_counterOverflowIrq;
      end
   end

   // Output pins and channel pulses
   always_comb begin
      next_timerOutputCh0     = timerOutputCh0;
      next_timerOutputCh1     = timerOutputCh1;
      next_channelEventIrqCh0 = ch0Hit;
      next_channelEventIrqCh1 = ch1Hit;
      if (!running) begin
         // Stopped pins sit at the idle low level
         next_timerOutputCh0 = 1'b0;
         next_timerOutputCh1 = 1'b0;
      end else if (startEvent) begin
         next_timerOutputCh0 = !timerOutputCh0;
         next_timerOutputCh1 = !timerOutputCh1;
      end else begin
         // Capture hits never reach the pins
         if (ch0Hit && !ch0Capture) begin
            next_timerOutputCh0 = !timerOutputCh0;
         end
         if (ch1Hit && !ch1Capture) begin
            next_timerOutputCh1 = !timerOutputCh1;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         timerOutputCh0     <= 1'b0;
         timerOutputCh1     <= 1'b0;
         channelEventIrqCh0 <= 1'b0;
         channelEventIrqCh1 <= 1'b0;
      end else begin
         timerOutputCh0     <= next_timerOutputCh0;
         timerOutputCh1     <= next_timerOutputCh1;
         channelEventIrqCh0 <= next_channelEventIrqCh0;
         channelEventIrqCh1 <= next_channelEventIrqCh1;
      end
   end

   // Address decode for the error answer; the read mux decodes paddr itself
   always_comb begin
      unique case (paddr)
         free_running_timer_pkg::ADDR_CONTROL,
         free_running_timer_pkg::ADDR_OPTION,
         free_running_timer_pkg::ADDR_OVF_CLEAR,
         free_running_timer_pkg::ADDR_COUNT,
         free_running_timer_pkg::ADDR_CCR0,
         free_running_timer_pkg::ADDR_CCR1: selKnown = 1'b1;
         default:                           selKnown = 1'b0;
      endcase
   end

   // One wait state: data is prepared in the first access cycle
   always_comb begin
      next_pready  = 1'b0;
      next_pslverr = 1'b0;
      next_prdata  = 32'h0000_0000;
      if (psel && penable && !pready) begin
         next_pready  = 1'b1;
         next_pslverr = !selKnown;
         if (!pwrite) begin
            unique case (paddr)
               free_running_timer_pkg::ADDR_CONTROL: begin
                  next_prdata[free_running_timer_pkg::MODE_MSB:
                              free_running_timer_pkg::MODE_LSB] = modeSelect;
                  next_prdata[free_running_timer_pkg::ENABLE_BIT] = countEnable;
               end
               free_running_timer_pkg::ADDR_OPTION: begin
                  next_prdata[free_running_timer_pkg::OVF_BIT]  = overflowFlag;
                  next_prdata[free_running_timer_pkg::CCS0_BIT] = ch0Capture;
                  next_prdata[free_running_timer_pkg::CCS1_BIT] = ch1Capture;
               end
               free_running_timer_pkg::ADDR_COUNT: begin
                  next_prdata[15:0] = count;
               end
               free_running_timer_pkg::ADDR_CCR0: begin
                  next_prdata[15:0] = ccr0Value;
               end
               free_running_timer_pkg::ADDR_CCR1: begin
                  next_prdata[15:0] = ccr1Value;
               end
               default: begin
                  next_prdata = 32'h0000_0000;
               end
            endcase
         end
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         prdata  <= 32'h0000_0000;
         pready  <= 1'b0;
         pslverr <= 1'b0;
      end else begin
         prdata  <= next_prdata;
         pready  <= next_pready;
         pslverr <= next_pslverr;
      end
   end
endmodule

//--- bench/free_running_timer_chk.sv
// Purpose: Concurrent checks on bus timing, pin levels and event pulses
// Assumes: Bench writes whole control words, so the run state is decoded here
// Notes:   A wrap takes 262144 cycles, so the overflow check stays passive
`timescale 1ns/1ps
module free_running_timer_chk (
   input wire logic        clk,
   input wire logic        reset,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [7:0]  paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic        pready,
   input wire logic        pslverr,
   input wire logic        timerOutputCh0,
   input wire logic        timerOutputCh1,
   input wire logic        channelEventIrqCh0,
   input wire logic        channelEventIrqCh1,
   input wire logic        counterOverflowIrq
);
   logic ctlWr;
   logic badAddr;
   logic run;
   logic next_run;

   // Completed control writes and unmapped addresses
   assign ctlWr = psel && penable && pready && pwrite
                  && paddr == free_running_timer_pkg::ADDR_CONTROL;
   assign badAddr = paddr > free_running_timer_pkg::ADDR_CCR1 || paddr[1:0] != 2'h0;

   // Shadow run state; lane mask ignored since whole words are written
   always_comb begin
      next_run = run;
      if (ctlWr) begin
         next_run = pwdata[free_running_timer_pkg::ENABLE_BIT]
                    && pwdata[2:0] == free_running_timer_pkg::MODE_FREE_RUN;
      end
   end

   // Shadow register
   always_ff @(posedge clk) begin
      run <= reset ? 1'b0 : next_run;
   end

   default clocking cb @(posedge clk); endclocking
   default disable iff (reset);

   sequence accessStart;
      psel && penable && !$past(penable);
   endsequence
   sequence startWrite;
      ctlWr && !run && next_run;
   endsequence
   sequence stopWrite;
      ctlWr && run && !next_run;
   endsequence

   chk_ready_wait: assert property (accessStart |-> !pready ##1 pready)
      else $error("pready not in second access cycle");
   chk_ready_pulse: assert property (pready |=> !pready)
      else $error("pready longer than one cycle");
   chk_rdata_idle: assert property (!pready |-> prdata == 32'h0)
      else $error("prdata not zero outside answer");
   chk_err_unmapped: assert property (pready |-> pslverr == badAddr)
      else $error("pslverr does not match address map");
   chk_start_pins: assert property (startWrite |-> ##2 (timerOutputCh0 && timerOutputCh1))
      else $error("pins not inverted at start");
   chk_stop_pins: assert property (stopWrite |-> ##2 (!timerOutputCh0 && !timerOutputCh1) [*3])
      else $error("pins not low after stop");
   chk_idle_pins: assert property (!run && !$past(run, 2) |-> !timerOutputCh0 && !timerOutputCh1)
      else $error("pins moved while not running");
   chk_irq0_pulse: assert property (channelEventIrqCh0 |=> !channelEventIrqCh0)
      else $error("channel 0 request longer than one cycle");
   chk_irq1_pulse: assert property (channelEventIrqCh1 |=> !channelEventIrqCh1)
      else $error("channel 1 request longer than one cycle");
   chk_ovf_pulse: assert property (counterOverflowIrq |=> !counterOverflowIrq)
      else $error("overflow request longer than one cycle");
   chk_ovf_run: assert property (counterOverflowIrq |-> $past(run))
      else $error("overflow request while stopped");
endmodule

bind free_running_timer free_running_timer_chk chk (
   .clk(clk), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite),
   .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
   .timerOutputCh0(timerOutputCh0), .timerOutputCh1(timerOutputCh1),
   .channelEventIrqCh0(channelEventIrqCh0), .channelEventIrqCh1(channelEventIrqCh1),
   .counterOverflowIrq(counterOverflowIrq));

//--- bench/trigger_source.sv
// Purpose: Far side: capture trigger sources and timer pin watchers
// Assumes: Triggers synchronous to clk, low when idle
// Notes:   Hold length lets the bench give short or long pulses
`timescale 1ns/1ps
module trigger_source (
   input wire logic        clk,
   input wire logic        reset,
   input wire logic [1:0]  pulseReq,
   input wire logic [3:0]  holdLen,
   input wire logic        pin0,
   input wire logic        pin1,
   output logic            trig0,
   output logic            trig1,
   output logic [15:0]     pinEdges0,
   output logic [15:0]     pinEdges1
);
   logic [3:0] left0;
   logic [3:0] left1;
   logic       pinQ0;
   logic       pinQ1;

   // One rising edge per request, held for holdLen cycles
   always_ff @(posedge clk) begin
      if (reset) begin
         {left0, left1, trig0, trig1} <= '0;
      end else begin
         left0 <= pulseReq[0] ? holdLen : left0 - 4'(left0 != 4'h0);
         left1 <= pulseReq[1] ? holdLen : left1 - 4'(left1 != 4'h0);
         trig0 <= pulseReq[0] || left0 > 4'h1;
         trig1 <= pulseReq[1] || left1 > 4'h1;
      end
   end

   // Pin edge counters, so square waves can be judged
   always_ff @(posedge clk) begin
      if (reset) begin
         {pinQ0, pinQ1, pinEdges0, pinEdges1} <= '0;
      end else begin
         pinQ0 <= pin0;
         pinQ1 <= pin1;
         pinEdges0 <= pinEdges0 + 16'(pin0 != pinQ0);
         pinEdges1 <= pinEdges1 + 16'(pin1 != pinQ1);
      end
   end
endmodule

//--- bench/free_running_timer_tb.sv
// Purpose: Self-checking bench for the free-running timer
// Assumes: APB answer after one wait state; triggers from trigger_source
// Notes:   A wrap needs 262144 cycles, so overflow is left to the checker
`timescale 1ns/1ps
module free_running_timer_tb;
   localparam int          PERIOD   = 16; // Compare interval in ticks
   localparam logic [31:0] RUN_WORD = (32'h1 << free_running_timer_pkg::ENABLE_BIT)
                                      | 32'(free_running_timer_pkg::MODE_FREE_RUN);
   logic        clk = 1'b0;
   logic        reset = 1'b1;
   logic        psel = 1'b0;
   logic        penable = 1'b0;
   logic        pwrite = 1'b0;
   logic [7:0]  paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic [3:0]  pstrb = 4'hF;
   logic [31:0] prdata;
   logic        pready;
   logic        pslverr;
   logic        trig0;
   logic        trig1;
   logic        pin0;
   logic        pin1;
   logic        irq0;
   logic        irq1;
   logic [1:0]  pulseReq = 2'h0;
   logic [3:0]  holdLen = 4'h1;
   logic [15:0] edges0;
   logic        ovf;
   int          nOvf = 0;
   int          n_errors = 0;
   int          checks = 0;
   int          cyc = 0;

   // 200 MHz clock and a cycle count for interval checks
   always #2.5 clk = ~clk;
   always @(posedge clk) cyc <= cyc + 1;
   // Overflow requests, counted as software would in its overflow handler
   always @(posedge clk) nOvf <= nOvf + int'(ovf === 1'b1);

   free_running_timer uut (.clk(clk), .reset(reset), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .captureTriggerCh0(trig0),
      .captureTriggerCh1(trig1), .timerOutputCh0(pin0), .timerOutputCh1(pin1),
      .channelEventIrqCh0(irq0), .channelEventIrqCh1(irq1), .counterOverflowIrq(ovf));
   trigger_source far (.clk(clk), .reset(reset), .pulseReq(pulseReq), .holdLen(holdLen),
      .pin0(pin0), .pin1(pin1), .trig0(trig0), .trig1(trig1), .pinEdges0(edges0),
      .pinEdges1());

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp) begin
         n_errors++;
         $display("ERROR at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   // Master holds the request until pready is seen; bounded wait
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] r, output logic e);
      int n;
      n = 0;
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      // Answer taken at the very rising edge that shows pready high
      do begin
         @(posedge clk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      r = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      chk(32'(n < 50), 32'h1);
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] r;
      logic        e;
      apb(1'b1, a, d, r, e);
   endtask

   task automatic rd(input logic [7:0] a, output logic [31:0] r);
      logic e;
      apb(1'b0, a, 32'h0, r, e);
   endtask

   task automatic waitIrq(input logic ch, output int at);
      int n;
      n = 0;
      do begin
         @(negedge clk);
         n++;
      end while ((ch ? irq1 : irq0) !== 1'b1 && n < 400);
      at = cyc;
      chk(32'(n < 400), 32'h1);
   endtask

   // Caller stands at a rising edge
   task automatic pulse(input int ch, output int at);
      at = cyc;
      pulseReq[ch] <= 1'b1;
      @(posedge clk);
      pulseReq[ch] <= 1'b0;
   endtask

   task automatic start(input logic [31:0] opt, input logic [15:0] c0, input logic [15:0] c1);
      wr(free_running_timer_pkg::ADDR_OPTION, opt);
      wr(free_running_timer_pkg::ADDR_CCR0, {16'h0, c0});
      wr(free_running_timer_pkg::ADDR_CCR1, {16'h0, c1});
      wr(free_running_timer_pkg::ADDR_CONTROL, RUN_WORD);
      repeat (2) @(negedge clk);
   endtask

   task automatic t_reset;
      logic [7:0]  regs [5];
      logic [31:0] r;
      logic        e;
      regs = '{free_running_timer_pkg::ADDR_CONTROL, free_running_timer_pkg::ADDR_OPTION,
               free_running_timer_pkg::ADDR_COUNT, free_running_timer_pkg::ADDR_CCR0,
               free_running_timer_pkg::ADDR_CCR1};
      foreach (regs[i]) begin
         rd(regs[i], r);
         chk(r, 32'h0);
      end
      apb(1'b0, 8'h18, 32'h0, r, e);
      chk({r[30:0], e}, 32'h1);
      // Count is read only; enable with a wrong mode must not run
      wr(free_running_timer_pkg::ADDR_COUNT, 32'h1234);
      wr(free_running_timer_pkg::ADDR_CONTROL, 32'h1 << free_running_timer_pkg::ENABLE_BIT);
      repeat (20) @(posedge clk);
      rd(free_running_timer_pkg::ADDR_COUNT, r);
      chk(r, 32'h0);
      chk({30'h0, pin1, pin0}, 32'h0);
   endtask

   task automatic t_compare;
      int          t0;
      int          t1;
      logic [31:0] r;
      logic [15:0] nextCmp;
      start(32'h0, 16'(PERIOD - 1), 16'h0005);
      chk({30'h0, pin1, pin0}, 32'h3);
      waitIrq(1'b1, t0);
      chk({30'h0, pin1, pin0}, 32'h1);
      waitIrq(1'b0, t0);
      chk({30'h0, pin1, pin0}, 32'h0);
      // Sixteen-bit sum drops any carry past FFFFH
      nextCmp = 16'(PERIOD - 1) + 16'(PERIOD);
      wr(free_running_timer_pkg::ADDR_CCR0, {16'h0, nextCmp});
      waitIrq(1'b0, t1);
      chk(32'(t1 - t0), 32'(PERIOD * free_running_timer_pkg::COUNT_TICK_DIV));
      chk({31'h0, pin0}, 32'h1);
      wr(free_running_timer_pkg::ADDR_CONTROL, 32'h0);
      repeat (2) @(negedge clk);
      chk({30'h0, pin1, pin0}, 32'h0);
      rd(free_running_timer_pkg::ADDR_COUNT, r);
      chk(r, 32'h0);
      rd(free_running_timer_pkg::ADDR_CCR0, r);
      chk(r, {16'h0, nextCmp});
   endtask

   // Two edges a whole number of ticks apart give an exact difference
   task automatic t_capture;
      int          t0;
      int          t1;
      logic [31:0] a;
      logic [31:0] b;
      logic [15:0] e0;
      int          n0;
      start(32'h1 << free_running_timer_pkg::CCS0_BIT, 16'h0000, 16'hFFF0);
      @(posedge clk);
      pulse(0, t0);
      // Start toggle is counted by now, so only compare toggles remain
      e0 = edges0;
      waitIrq(1'b0, t1);
      rd(free_running_timer_pkg::ADDR_CCR0, a);
      n0 = nOvf;
      holdLen <= 4'h3;
      while (cyc != t0 + 10 * free_running_timer_pkg::COUNT_TICK_DIV) @(posedge clk);
      pulse(0, t1);
      waitIrq(1'b0, t1);
      rd(free_running_timer_pkg::ADDR_CCR0, b);
      chk((b - a) & 32'hFFFF, 32'h000A);
      chk(32'(nOvf - n0) * 32'h10000 + b - a, 32'h000A);
      chk(32'(edges0 - e0), 32'h0);
      pulse(1, t1);
      repeat (20) @(posedge clk);
      rd(free_running_timer_pkg::ADDR_CCR0, a);
      chk(a, b);
      rd(free_running_timer_pkg::ADDR_CCR1, a);
      chk(a, 32'hFFF0);
      wr(free_running_timer_pkg::ADDR_CONTROL, 32'h0);
   endtask

   // Flag must read clear; bit clear is written once, or twice when it was seen set
   task automatic t_flag;
      logic [31:0] r;
      rd(free_running_timer_pkg::ADDR_OPTION, r);
      chk(r & 32'h1, 32'h0);
      if (r[free_running_timer_pkg::OVF_BIT]) wr(free_running_timer_pkg::ADDR_OVF_CLEAR, 32'h1);
      wr(free_running_timer_pkg::ADDR_OVF_CLEAR, 32'h1);
      rd(free_running_timer_pkg::ADDR_OPTION, r);
      chk(r, 32'h0);
   endtask

   task automatic print_verdict;
      $display("Checks %0d errors %0d", checks, n_errors);
      if (n_errors == 0 && checks > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask

   // Main sequence
   initial begin
      repeat (4) @(posedge clk);
      reset <= 1'b0;
      t_reset();
      t_flag();
      t_compare();
      t_capture();
      print_verdict();
   end

   // Watchdog, well beyond the expected run of under 2000 cycles
   initial begin
      repeat (20000) @(posedge clk);
      n_errors++;
      print_verdict();
   end
endmodule
